// file: src/bic_branch_ctrl.v
// branch, call, compare-branch and if-then block control
`timescale 1ns/10ps
`default_nettype none
`include "bic_defines.vh"
module bic_branch_ctrl
(
  // clock and reset
  input  wire        clk_i,
  input  wire        arst_n_i,
  // pre-decoded instruction
  input  wire        instr_valid_i,
  input  wire [3:0]  instr_op_i,
  input  wire        instr_wide_i,
  input  wire [3:0]  instr_cond_i,
  input  wire [24:0] instr_disp_i,
  input  wire [3:0]  instr_reg_i,
  input  wire [31:0] reg_val_i,
  input  wire [31:0] pc_i,
  input  wire [2:0]  it_switch_i,
  input  wire [1:0]  it_extra_i,
  // condition flags
  input  wire [3:0]  flags_i,
  // exception save and restore of block state
  input  wire        it_restore_i,
  input  wire [9:0]  it_restore_val_i,
  // results
  output reg         done_o,
  output reg         exec_o,
  output reg         branch_o,
  output reg  [31:0] target_o,
  output reg         link_we_o,
  output reg  [31:0] link_o,
  output reg         fault_o,
  output reg         undef_o,
  output reg  [3:0]  flags_o,
  output reg         in_block_o,
  output reg  [9:0]  it_state_o
);
  // block state: base condition, pending switches, remaining slots
  reg  [3:0]  base_r;
  reg  [3:0]  base_nxt;
  reg  [2:0]  sw_r;
  reg  [2:0]  sw_nxt;
  reg  [2:0]  rem_r;
  reg  [2:0]  rem_nxt;
  wire        in_block = (rem_r != 3'h0);

  // the slot's condition: first slot and same_sense use the base, flip inverts
  reg  [3:0]  slot_cond;
  always @*
  begin
    slot_cond = instr_cond_i;
    if (in_block)
      slot_cond = base_r;
  end
  wire        slot_flip = in_block & ~sw_r[2];
  wire [3:0]  eval_cond = {slot_cond[3:1], slot_cond[0] ^ slot_flip};

  wire        cond_pass;
  bic_cond_eval u_cond
  (
    .cond_i  (eval_cond),
    .flags_i (flags_i),
    .pass_o  (cond_pass)
  );

  // displacement sign extension from the encoding's field width
  reg  [4:0]  disp_w;
  reg  [31:0] disp;
  wire        op_jimm = (instr_op_i == `BIC_OP_JUMP_IMM);
  wire        op_cj   = (instr_op_i == `BIC_OP_COND_JUMP);
  wire        op_cimm = (instr_op_i == `BIC_OP_CALL_IMM);
  wire        op_jreg = (instr_op_i == `BIC_OP_JUMP_REG);
  wire        op_creg = (instr_op_i == `BIC_OP_CALL_REG);
  wire        op_cz   = (instr_op_i == `BIC_OP_CMP_ZERO);
  wire        op_cnz  = (instr_op_i == `BIC_OP_CMP_NZ);
  wire        op_it   = (instr_op_i == `BIC_OP_IT_PREFIX);
  wire        op_bkpt = (instr_op_i == `BIC_OP_BKPT);

  always @*
  begin
    disp_w = `BIC_DW_J_WIDE;
    // inside a block the condition lives in the prefix, freeing encoding bits
    if (op_cj & ~in_block)
      disp_w = instr_wide_i ? `BIC_DW_CJ_WIDE : `BIC_DW_CJ_NARROW;
    else if (op_cj | op_jimm)
      disp_w = instr_wide_i ? `BIC_DW_J_WIDE : `BIC_DW_J_NARROW;
    case (disp_w)
      `BIC_DW_CJ_NARROW: disp = {{23{instr_disp_i[8]}}, instr_disp_i[8:0]};
      `BIC_DW_J_NARROW:  disp = {{20{instr_disp_i[11]}}, instr_disp_i[11:0]};
      `BIC_DW_CJ_WIDE:   disp = {{11{instr_disp_i[20]}}, instr_disp_i[20:0]};
      default:           disp = {{7{instr_disp_i[24]}}, instr_disp_i};
    endcase
  end

  // addresses
  wire [31:0] pc_rel   = pc_i + `BIC_PC_AHEAD + disp;
  wire [31:0] reg_tgt  = {reg_val_i[31:1], 1'b0};
  wire [31:0] cmp_off  = {25'h0, instr_disp_i[5:0], 1'b0};
  wire [31:0] cmp_tgt  = pc_i + `BIC_CMP_BASE + cmp_off;
  wire [31:0] isize    = instr_wide_i ? `BIC_SIZE_WIDE : `BIC_SIZE_NARROW;
  wire [31:0] next_pc  = pc_i + isize;
  wire        is_zero  = (reg_val_i == 32'h0000_0000);
  wire        low_reg  = (instr_reg_i <= `BIC_LOW_REG_MAX);

  // execution decision
  reg         exec;
  reg         take;
  reg [31:0]  tgt;
  reg         lwe;
  reg         flt;
  reg         und;
  always @*
  begin
    exec = 1'b1;
    take = 1'b0;
    tgt  = next_pc;
    lwe  = 1'b0;
    flt  = 1'b0;
    und  = 1'b0;
    if (in_block)
      exec = cond_pass | op_bkpt;
    else if (op_cj)
      exec = cond_pass;
    if (in_block & (op_it | op_cz | op_cnz))
    begin
      exec = 1'b0;
      und  = 1'b1;
    end
    else if ((op_cz | op_cnz) & ~low_reg)
    begin
      exec = 1'b0;
      und  = 1'b1;
    end
    if (exec)
    begin
      case (instr_op_i)
        `BIC_OP_JUMP_IMM, `BIC_OP_COND_JUMP:
        begin
          take = 1'b1;
          tgt  = pc_rel;
        end
        `BIC_OP_CALL_IMM:
        begin
          take = 1'b1;
          tgt  = pc_rel;
          lwe  = 1'b1;
        end
        `BIC_OP_JUMP_REG, `BIC_OP_CALL_REG:
        begin
          if (!reg_val_i[0])
            flt = 1'b1;
          else
          begin
            take = 1'b1;
            tgt  = reg_tgt;
            lwe  = op_creg;
          end
        end
        `BIC_OP_CMP_ZERO, `BIC_OP_CMP_NZ:
        begin
          take = op_cz ? is_zero : ~is_zero;
          tgt  = take ? cmp_tgt : next_pc;
        end
        default:
        begin
          take = 1'b0;
          tgt  = next_pc;
        end
      endcase
    end
  end

  // block state update
  always @*
  begin
    base_nxt = base_r;
    sw_nxt   = sw_r;
    rem_nxt  = rem_r;
    if (it_restore_i)
    begin
      base_nxt = it_restore_val_i[9:6];
      sw_nxt   = it_restore_val_i[5:3];
      rem_nxt  = it_restore_val_i[2:0];
    end
    else if (instr_valid_i)
    begin
      if (in_block)
      begin
        sw_nxt  = {sw_r[1:0], 1'b1};
        rem_nxt = rem_r - 3'h1;
        // a taken branch leaves the block; code places it last anyway
        if (take | flt)
          rem_nxt = 3'h0;
      end
      else if (op_it)
      begin
        base_nxt = instr_cond_i;
        // slot one always runs on the base; the first switch covers slot two
        sw_nxt   = {1'b1, it_switch_i[2:1]};
        rem_nxt  = {1'b0, it_extra_i} + 3'h1;
      end
    end
  end

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      base_r     <= `BIC_COND_AL;
      sw_r       <= 3'h7;
      rem_r      <= 3'h0;
      done_o     <= 1'b0;
      exec_o     <= 1'b0;
      branch_o   <= 1'b0;
      target_o   <= 32'h0000_0000;
      link_we_o  <= 1'b0;
      link_o     <= 32'h0000_0000;
      fault_o    <= 1'b0;
      undef_o    <= 1'b0;
      flags_o    <= 4'h0;
      in_block_o <= 1'b0;
      it_state_o <= 10'h000;
    end
    else
    begin
      base_r     <= base_nxt;
      // slot one runs on the base; the shift brings slot two's switch to bit 2
      sw_r       <= sw_nxt;
      rem_r      <= rem_nxt;
      done_o     <= instr_valid_i;
      exec_o     <= instr_valid_i & exec & ~flt;
      branch_o   <= instr_valid_i & take;
      target_o   <= tgt;
      link_we_o  <= instr_valid_i & lwe;
      // return address keeps bit 0 set so a later register return stays legal
      link_o     <= {next_pc[31:1], 1'b1};
      fault_o    <= instr_valid_i & flt;
      undef_o    <= instr_valid_i & und;
      flags_o    <= flags_i;
      in_block_o <= (rem_nxt != 3'h0);
      it_state_o <= {base_nxt, sw_nxt, rem_nxt};
    end
  end
endmodule
`default_nettype wire

// file: src/bic_defines.vh
// constants and behaviour notes for the branch and if-then control block
`ifndef BIC_DEFINES_VH
`define BIC_DEFINES_VH
// operation codes from the pre-decoder
`define BIC_OP_OTHER     4'h0
`define BIC_OP_JUMP_IMM  4'h1
`define BIC_OP_COND_JUMP 4'h2
`define BIC_OP_CALL_IMM  4'h3
`define BIC_OP_JUMP_REG  4'h4
`define BIC_OP_CALL_REG  4'h5
`define BIC_OP_CMP_ZERO  4'h6
`define BIC_OP_CMP_NZ    4'h7
`define BIC_OP_IT_PREFIX 4'h8
`define BIC_OP_BKPT      4'h9
// condition codes
`define BIC_COND_AL      4'hE
// displacement field widths in bits
`define BIC_DW_CJ_NARROW 5'd9
`define BIC_DW_J_NARROW  5'd12
`define BIC_DW_CJ_WIDE   5'd21
`define BIC_DW_J_WIDE    5'd25
// pipeline view of program counter and instruction sizes
`define BIC_PC_AHEAD     32'h0000_0004
`define BIC_SIZE_NARROW  32'h0000_0002
`define BIC_SIZE_WIDE    32'h0000_0004
// compare branch: base offset and low register limit
`define BIC_CMP_BASE     32'h0000_0004
`define BIC_LOW_REG_MAX  4'h7
// block slot count field
`define BIC_SLOTS_MAX    3'h4
`define BIC_STATE_W      10
`endif

// file: src/bic_cond_eval.v
// condition code evaluator against the nzcv flags
`timescale 1ns/10ps
`default_nettype none
module bic_cond_eval
(
  // condition and flags
  input  wire [3:0] cond_i,
  input  wire [3:0] flags_i,
  // result
  output reg        pass_o
);
  wire n = flags_i[3];
  wire z = flags_i[2];
  wire c = flags_i[1];
  wire v = flags_i[0];
  reg  base;

  // low bit of the code inverts the pair; code F is treated as always
  always @*
  begin
    base = 1'b1;
    case (cond_i[3:1])
      3'h0: base = z;
      3'h1: base = c;
      3'h2: base = n;
      3'h3: base = v;
      3'h4: base = c & ~z;
      3'h5: base = (n == v);
      3'h6: base = ~z & (n == v);
      default: base = 1'b1;
    endcase
    if (cond_i[3:1] == 3'h7)
      pass_o = 1'b1;
    else
      pass_o = base ^ cond_i[0];
  end
endmodule
`default_nettype wire

// file: tb/bic_branch_sva.sv
// checker for the branch and if-then control block ports
`timescale 1ns/10ps
`default_nettype none
`include "bic_defines.vh"
module bic_branch_sva
(
  // clock and reset
  input wire logic        clk_i,
  input wire logic        arst_n_i,
  // instruction side
  input wire logic        instr_valid_i,
  input wire logic [3:0]  instr_op_i,
  input wire logic        instr_wide_i,
  input wire logic [24:0] instr_disp_i,
  input wire logic [3:0]  instr_reg_i,
  input wire logic [31:0] reg_val_i,
  input wire logic [31:0] pc_i,
  input wire logic [1:0]  it_extra_i,
  input wire logic [3:0]  flags_i,
  input wire logic        it_restore_i,
  // results
  input wire logic        exec_o,
  input wire logic        branch_o,
  input wire logic [31:0] target_o,
  input wire logic        link_we_o,
  input wire logic [31:0] link_o,
  input wire logic        fault_o,
  input wire logic        undef_o,
  input wire logic [3:0]  flags_o,
  input wire logic        in_block_o,
  input wire logic [9:0]  it_state_o
);
  // only unpredicated instructions, so the outcome never hangs on a condition
  wire logic take_w = instr_valid_i & ~it_restore_i & ~in_block_o;
  wire logic regj_w = take_w && (instr_op_i == `BIC_OP_JUMP_REG || instr_op_i == `BIC_OP_CALL_REG);
  wire logic cmp_w  = take_w && instr_reg_i <= 4'h7 && reg_val_i == 32'h0;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  flags_keep_a: assert property (
    1'h1 |=> flags_o == $past(flags_i)) else $error("flags changed");
  call_link_a: assert property (
    take_w && instr_op_i == `BIC_OP_CALL_IMM |=> link_we_o &&
    link_o == (($past(pc_i) + ($past(instr_wide_i) ? 32'h4 : 32'h2)) | 32'h1)) else $error("bad link");
  reg_fault_a: assert property (
    regj_w && !reg_val_i[0] |=> fault_o && !branch_o) else $error("no fault on even target");
  reg_target_a: assert property (
    regj_w && reg_val_i[0] |=> branch_o && target_o == {$past(reg_val_i[31:1]), 1'h0}) else $error("bad target");
  cmp_target_a: assert property (
    cmp_w && instr_op_i == `BIC_OP_CMP_ZERO |=> branch_o &&
    target_o == $past(pc_i) + 32'h4 + {$past(instr_disp_i[5:0]), 1'h0}) else $error("bad compare target");
  cmp_skip_a: assert property (
    cmp_w && instr_op_i == `BIC_OP_CMP_NZ |=> !branch_o) else $error("nonzero branch on zero");
  low_reg_a: assert property (
    take_w && instr_op_i[3:1] == 3'h3 && instr_reg_i > 4'h7 |=> undef_o && !exec_o) else $error("high reg ok");
  block_len_a: assert property (
    take_w && instr_op_i == `BIC_OP_IT_PREFIX |=> in_block_o &&
    it_state_o[2:0] == $past(it_extra_i) + 3'h1) else $error("bad block length");
endmodule
bind bic_branch_ctrl bic_branch_sva u_sva (.clk_i, .arst_n_i, .instr_valid_i, .instr_op_i, .instr_wide_i,
  .instr_disp_i, .instr_reg_i, .reg_val_i, .pc_i, .it_extra_i, .flags_i, .it_restore_i, .exec_o, .branch_o,
  .target_o, .link_we_o, .link_o, .fault_o, .undef_o, .flags_o, .in_block_o, .it_state_o);
`default_nettype wire

// file: tb/bic_prog_rom.sv
// program store that feeds pre-decoded instructions
`timescale 1ns/10ps
`default_nettype none
module bic_prog_rom
(
  // slot select
  input  wire logic [3:0]   slot_i,
  // {op, wide, cond, disp, reg, value, pc, switch, extra}
  output var  logic [106:0] word_o
);
  always_comb
  begin
    case (slot_i)
      4'h0: word_o = {4'h3, 1'h1, 4'hE, 25'h10, 4'h1, 32'h0, 32'h100, 3'h7, 2'h0};
      4'h1: word_o = {4'h4, 1'h0, 4'hE, 25'h0, 4'h1, 32'h201, 32'h0, 3'h7, 2'h0};
      4'h2: word_o = {4'h5, 1'h0, 4'hE, 25'h0, 4'h2, 32'h200, 32'h0, 3'h7, 2'h0};
      4'h3: word_o = {4'h6, 1'h0, 4'hE, 25'h3, 4'h3, 32'h0, 32'h40, 3'h7, 2'h0};
      4'h4: word_o = {4'h7, 1'h0, 4'hE, 25'h3, 4'h3, 32'h0, 32'h40, 3'h7, 2'h0};
      4'h5: word_o = {4'h6, 1'h0, 4'hE, 25'h3, 4'h8, 32'h0, 32'h40, 3'h7, 2'h0};
      4'h6: word_o = {4'h8, 1'h0, 4'h0, 25'h0, 4'h0, 32'h0, 32'h300, 3'h3, 2'h1};
      4'h8: word_o = {4'h2, 1'h0, 4'h0, 25'h100, 4'h0, 32'h0, 32'h400, 3'h7, 2'h0};
      4'h9: word_o = {4'h8, 1'h0, 4'h0, 25'h0, 4'h0, 32'h0, 32'h300, 3'h7, 2'h1};
      4'hC: word_o = {4'h8, 1'h0, 4'hE, 25'h0, 4'h0, 32'h0, 32'h300, 3'h7, 2'h0};
      4'hA: word_o = {4'h9, 1'h0, 4'hE, 25'h0, 4'h0, 32'h0, 32'h302, 3'h7, 2'h0};
      4'hB: word_o = {4'h1, 1'h1, 4'hE, 25'h1000000, 4'h0, 32'h0, 32'h1000000, 3'h7, 2'h0};
      default: word_o = {4'h0, 1'h0, 4'hE, 25'h0, 4'h0, 32'h0, 32'h304, 3'h7, 2'h0};
    endcase
  end
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the branch and if-then control block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_i = 1'h0, arst_n_i = 1'h0, instr_valid_i = 1'h0, it_restore_i = 1'h0;
  logic [3:0] slot = 4'h0, flags_i = 4'h0;
  logic [9:0] it_restore_val_i = 10'h0;
  wire logic [106:0] word;
  wire logic instr_wide_i, done_o, exec_o, branch_o, link_we_o, fault_o, undef_o, in_block_o;
  wire logic [3:0] instr_op_i, instr_cond_i, instr_reg_i, flags_o;
  wire logic [24:0] instr_disp_i;
  wire logic [31:0] reg_val_i, pc_i, target_o, link_o;
  wire logic [2:0] it_switch_i;
  wire logic [1:0] it_extra_i;
  wire logic [9:0] it_state_o;
  int errors = 0, compares = 0, cyc = 0;
  assign {instr_op_i, instr_wide_i, instr_cond_i, instr_disp_i, instr_reg_i, reg_val_i, pc_i, it_switch_i,
    it_extra_i} = word;
  bic_prog_rom u_rom (.slot_i(slot), .word_o(word));
  bic_branch_ctrl DUT (.clk_i, .arst_n_i, .instr_valid_i, .instr_op_i, .instr_wide_i, .instr_cond_i,
    .instr_disp_i, .instr_reg_i, .reg_val_i, .pc_i, .it_switch_i, .it_extra_i, .flags_i, .it_restore_i,
    .it_restore_val_i, .done_o, .exec_o, .branch_o, .target_o, .link_we_o, .link_o, .fault_o, .undef_o,
    .flags_o, .in_block_o, .it_state_o);
  always #5 clk_i = ~clk_i;
  task automatic wrap_up;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // a hang is cut short well past the few dozen cycles the scenarios need
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 400)
    begin
      errors++;
      wrap_up;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one instruction per call; results are registered, so they are read a cycle later
  task automatic run(input logic [3:0] idx, input logic [3:0] flg);
    @(negedge clk_i);
    slot = idx;
    flags_i = flg;
    instr_valid_i = 1'h1;
    @(negedge clk_i);
    instr_valid_i = 1'h0;
  endtask
  task automatic t_call;
    run(4'h0, 4'hA);
    chk(done_o, 32'h1);
    chk(branch_o, 32'h1);
    chk(target_o, 32'h114);
    chk(link_we_o, 32'h1);
    chk(link_o, 32'h105);
    chk(flags_o, 32'hA);
  endtask
  task automatic t_reg;
    run(4'h1, 4'h0);
    chk(branch_o, 32'h1);
    chk(target_o, 32'h200);
    run(4'h2, 4'h0);
    chk(fault_o, 32'h1);
    chk(branch_o, 32'h0);
  endtask
  task automatic t_cmp;
    run(4'h3, 4'h5);
    chk(target_o, 32'h4A);
    chk(flags_o, 32'h5);
    run(4'h4, 4'h0);
    chk(branch_o, 32'h0);
    run(4'h5, 4'h0);
    chk(undef_o, 32'h1);
  endtask
  task automatic t_jump;
    run(4'hB, 4'h0);
    chk(target_o, 32'h4);
    run(4'h8, 4'h4);
    chk(target_o, 32'h304);
  endtask
  task automatic t_block;
    run(4'h6, 4'h4);
    chk(in_block_o, 32'h1);
    run(4'h7, 4'h4);
    chk(exec_o, 32'h1);
    run(4'h8, 4'h0);
    chk(target_o, 32'h504);
    chk(in_block_o, 32'h0);
    run(4'hC, 4'h0);
    run(4'h7, 4'h0);
    chk(exec_o, 32'h1);
  endtask
  task automatic t_bkpt;
    run(4'h9, 4'h0);
    run(4'hA, 4'h0);
    chk(exec_o, 32'h1);
    run(4'h7, 4'h0);
    chk(exec_o, 32'h0);
    chk(in_block_o, 32'h0);
  endtask
  // block state {base EQ, switches all same, one slot left} loaded as on exception return
  task automatic t_restore;
    @(negedge clk_i);
    it_restore_val_i = 10'h039;
    it_restore_i = 1'h1;
    @(negedge clk_i);
    it_restore_i = 1'h0;
    chk(in_block_o, 32'h1);
    chk(it_state_o, 32'h39);
    run(4'h7, 4'h4);
    chk(exec_o, 32'h1);
    chk(in_block_o, 32'h0);
  endtask
  initial
  begin
    repeat (2) @(negedge clk_i);
    arst_n_i = 1'h1;
    t_call;
    t_reg;
    t_cmp;
    t_jump;
    t_block;
    t_bkpt;
    t_restore;
    wrap_up;
  end
endmodule
`default_nettype wire
